/* File: hw/epf_pkg.sv */
// Constants, field layouts and the one helper function for the external bus pin function select block.
// Assumes one 100 MHz clock, a synchronous active-high reset and an APB register bus.
package epf_pkg;

  localparam int NUM_PORTS = 7;
  localparam int APB_AW    = 12;

  typedef logic [7:0]                epf_byte_type;
  typedef logic [NUM_PORTS-1:0][7:0] epf_ports_type;

  // Register byte offsets; each register is one aligned 32-bit word.
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_PORT0   = 12'h010;
  localparam logic [11:0] OFF_PORT_END = 12'h02C;

  // Control register fields.
  localparam int          CTRL_W          = 6;
  localparam int          CTRL_UPPER_ADDR = 0;
  localparam int          CTRL_CLK_OUT    = 1;
  localparam int          CTRL_READY      = 2;
  localparam int          CTRL_HOLD       = 3;
  localparam int          CTRL_WRH        = 4;
  localparam int          CTRL_WRL        = 5;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;

  // Port register fields: output data, direction (1 drives), pin level.
  localparam int PORT_OUT_LSB = 0;
  localparam int PORT_DIR_LSB = 8;
  localparam int PORT_PIN_LSB = 16;

  // Status register fields.
  localparam int ST_MODE_LSB = 0;
  localparam int ST_SINGLE   = 3;
  localparam int ST_MUXED    = 4;
  localparam int ST_BUS16    = 5;
  localparam int ST_HOLD_PIN = 6;
  localparam int ST_RDY_PIN  = 7;

  // Mode pin codes; any other code is taken as single-chip.
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_NMUX8  = 3'h1;
  localparam logic [2:0] MODE_NMUX16 = 3'h2;
  localparam logic [2:0] MODE_MUX8   = 3'h3;
  localparam logic [2:0] MODE_MUX16  = 3'h4;

  // Open-drain port starts released so nothing is pulled low out of reset.
  localparam epf_ports_type GPIO_OUT_RESET = {8'hFF, 48'h0000_0000_0000};
  localparam epf_ports_type GPIO_DIR_RESET = {8'h00, 48'h0000_0000_0000};
  localparam epf_byte_type  BYTE_ZERO      = 8'h00;
  localparam epf_byte_type  BYTE_ONES      = 8'hFF;

  // Selects a function or the GPIO latch for a byte; result is {drive, value}.
  function automatic logic [15:0] pin_byte(input logic         sel,
                                           input epf_byte_type fval,
                                           input epf_byte_type fdrv,
                                           input epf_byte_type gval,
                                           input epf_byte_type gdir);
    pin_byte = sel ? {fdrv, fval} : {gdir, gval};
  endfunction : pin_byte

endpackage : epf_pkg

/* File: hw/epf_cfg_if.sv */
// Carrier between the register file, the mode latch and the pin multiplexer.
// Assumes all three sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface epf_cfg_if;
  import epf_pkg::*;
  logic [CTRL_W-1:0] ctrl;
  epf_ports_type     gpio_out;
  epf_ports_type     gpio_dir;
  epf_ports_type     pin_in;
  logic [2:0]        mode_code;
  logic              single_chip;
  logic              muxed;
  logic              bus16;
  logic              hold_pin;
  logic              ready_pin;

  modport regs (output ctrl, gpio_out, gpio_dir,
                input  pin_in, mode_code, single_chip, muxed, bus16, hold_pin, ready_pin);
  modport mode (output mode_code, single_chip, muxed, bus16);
  modport mux  (input  ctrl, gpio_out, gpio_dir, single_chip, muxed, bus16,
                output pin_in, hold_pin, ready_pin);
endinterface : epf_cfg_if
`default_nettype wire

/* File: hw/epf_mode.sv */
// Latches the operating mode from the mode pins once after reset release.
// Assumes the mode pins are static and synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module epf_mode (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [2:0] i_mode_pins,
  epf_cfg_if.mode         cfg
);
  import epf_pkg::*;

  logic [2:0] code_q;
  logic       taken_q;

  // The pins are caught on the first edge after release, so a pin still settling
  // during reset cannot leave a half-decoded mode behind.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      code_q  <= MODE_SINGLE;
      taken_q <= 1'b0;
    end else if (!taken_q) begin
      code_q  <= i_mode_pins;
      taken_q <= 1'b1;
    end
  end

  // Decoded mode flags; unused codes fall back to single-chip.
  assign cfg.mode_code   = code_q;
  assign cfg.muxed       = (code_q == MODE_MUX8) || (code_q == MODE_MUX16);
  assign cfg.bus16       = (code_q == MODE_NMUX16) || (code_q == MODE_MUX16);
  assign cfg.single_chip = !(cfg.muxed || cfg.bus16 || (code_q == MODE_NMUX8));
endmodule : epf_mode
`default_nettype wire

/* File: hw/epf_regs.sv */
// APB slave holding the function enables and the GPIO latches of all seven ports.
// Assumes an APB master that holds its request until pready is seen high.
`timescale 1ns/10ps
`default_nettype none
module epf_regs (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  epf_cfg_if.regs          cfg
);
  import epf_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  epf_ports_type     out_q;
  epf_ports_type     dir_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       rdata_d;

  // Address decode; the port window is eight aligned words.
  wire        aligned  = (i_paddr[1:0] == 2'h0);
  wire        hit_ctrl = (i_paddr == OFF_CTRL);
  wire        hit_stat = (i_paddr == OFF_STATUS);
  wire        hit_port = aligned && (i_paddr >= OFF_PORT0) && (i_paddr <= OFF_PORT_END);
  wire [11:0] port_off = i_paddr - OFF_PORT0;
  wire [2:0]  port_idx = port_off[4:2];
  wire        hit      = hit_ctrl || hit_stat || hit_port;
  wire        access   = i_psel && i_penable;
  wire        wr_fire  = access && pready_q && i_pwrite && hit;

  // Read data; unmapped and reserved bits read zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_d[CTRL_W-1:0] = ctrl_q;
    end else if (hit_stat) begin
      rdata_d[ST_MODE_LSB +: 3] = cfg.mode_code;
      rdata_d[ST_SINGLE]        = cfg.single_chip;
      rdata_d[ST_MUXED]         = cfg.muxed;
      rdata_d[ST_BUS16]         = cfg.bus16;
      rdata_d[ST_HOLD_PIN]      = cfg.hold_pin;
      rdata_d[ST_RDY_PIN]       = cfg.ready_pin;
    end else if (hit_port) begin
      rdata_d[PORT_OUT_LSB +: 8] = out_q[port_idx];
      rdata_d[PORT_DIR_LSB +: 8] = dir_q[port_idx];
      rdata_d[PORT_PIN_LSB +: 8] = cfg.pin_in[port_idx];
    end
  end

  // One wait state: pready rises in the second access cycle, and the write lands
  // on that same completing edge so the master never sees a half-done transfer.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q    <= CTRL_RESET;
      out_q     <= GPIO_OUT_RESET;
      dir_q     <= GPIO_DIR_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
      if (access && !pready_q) begin
        prdata_q  <= rdata_d;
        pslverr_q <= !hit;
      end
      if (wr_fire && hit_ctrl) begin
        ctrl_q <= i_pwdata[CTRL_W-1:0];
      end
      if (wr_fire && hit_port) begin
        out_q[port_idx] <= i_pwdata[PORT_OUT_LSB +: 8];
        dir_q[port_idx] <= i_pwdata[PORT_DIR_LSB +: 8];
      end
    end
  end

  assign o_prdata     = prdata_q;
  assign o_pready     = pready_q;
  assign o_pslverr    = pslverr_q;
  assign cfg.ctrl     = ctrl_q;
  assign cfg.gpio_out = out_q;
  assign cfg.gpio_dir = dir_q;
endmodule : epf_regs
`default_nettype wire

/* File: hw/epf_top.sv */
// Top of the external bus pin function select block: chooses, pin by pin, between
// the GPIO latches and the external bus functions, and registers every pin output.
// Assumes the bus controller inputs and all pin inputs are synchronous to I_CLOCK,
// and that the pad ring resolves each pin from its output and active-low enable.
`timescale 1ns/10ps
`default_nettype none
module epf_top (
  input  wire logic        I_CLOCK,
  input  wire logic        I_SRST,
  // APB register bus.
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Static configuration and standby.
  input  wire logic [2:0]  I_MODE_SELECT_PINS,
  input  wire logic        I_HW_STANDBY_IN,
  // Internal bus controller side.
  input  wire logic [23:0] I_BUS_ADDR,
  input  wire logic [15:0] I_BUS_WDATA,
  input  wire logic        I_BUS_DATA_DRIVE,
  input  wire logic        I_BUS_ALE,
  input  wire logic        I_BUS_RD_N,
  input  wire logic        I_BUS_WRL_N,
  input  wire logic        I_BUS_WRH_N,
  input  wire logic        I_MACHINE_CLK,
  input  wire logic        I_HOLD_GRANT,
  output logic      [15:0] O_BUS_RDATA,
  output logic             O_EXT_READY,
  output logic             O_HOLD_REQUEST,
  // Port pins: input level, output value, active-low output enable.
  input  wire logic [7:0]  I_PORT0_GPIO_IN,
  output logic      [7:0]  O_PORT0_GPIO_OUT,
  output logic      [7:0]  O_PORT0_GPIO_OE_N,
  input  wire logic [7:0]  I_PORT1_GPIO_IN,
  output logic      [7:0]  O_PORT1_GPIO_OUT,
  output logic      [7:0]  O_PORT1_GPIO_OE_N,
  input  wire logic [7:0]  I_PORT2_GPIO_IN,
  output logic      [7:0]  O_PORT2_GPIO_OUT,
  output logic      [7:0]  O_PORT2_GPIO_OE_N,
  input  wire logic [7:0]  I_PORT3_GPIO_IN,
  output logic      [7:0]  O_PORT3_GPIO_OUT,
  output logic      [7:0]  O_PORT3_GPIO_OE_N,
  input  wire logic [7:0]  I_PORT4_GPIO_IN,
  output logic      [7:0]  O_PORT4_GPIO_OUT,
  output logic      [7:0]  O_PORT4_GPIO_OE_N,
  input  wire logic [7:0]  I_PORT5_GPIO_IN,
  output logic      [7:0]  O_PORT5_GPIO_OUT,
  output logic      [7:0]  O_PORT5_GPIO_OE_N,
  input  wire logic [7:0]  I_OPENDRAIN_PORT_IN,
  output logic      [7:0]  O_OPENDRAIN_PORT_OUT,
  output logic      [7:0]  O_OPENDRAIN_PORT_OE_N
);
  import epf_pkg::*;

  epf_cfg_if cfg ();

  // Mode latch.
  epf_mode u_mode (
    .i_clk       (I_CLOCK),
    .i_srst      (I_SRST),
    .i_mode_pins (I_MODE_SELECT_PINS),
    .cfg         (cfg.mode)
  );

  // Register file.
  epf_regs u_regs (
    .i_clk     (I_CLOCK),
    .i_srst    (I_SRST),
    .i_psel    (I_PSEL),
    .i_penable (I_PENABLE),
    .i_pwrite  (I_PWRITE),
    .i_paddr   (I_PADDR),
    .i_pwdata  (I_PWDATA),
    .o_prdata  (O_PRDATA),
    .o_pready  (O_PREADY),
    .o_pslverr (O_PSLVERR),
    .cfg       (cfg.regs)
  );

  // Pin levels go back to the register file for readback.
  assign cfg.pin_in = {I_OPENDRAIN_PORT_IN, I_PORT5_GPIO_IN, I_PORT4_GPIO_IN,
                       I_PORT3_GPIO_IN, I_PORT2_GPIO_IN, I_PORT1_GPIO_IN, I_PORT0_GPIO_IN};
  assign cfg.hold_pin  = I_PORT5_GPIO_IN[3];
  assign cfg.ready_pin = I_PORT5_GPIO_IN[1];

  // Mode and enable terms shared by the port selections.
  wire ext_bus   = !cfg.single_chip;
  wire non_mux   = ext_bus && !cfg.muxed;
  wire hold_on   = cfg.ctrl[CTRL_HOLD];
  // While the hold is enabled and granted the bus pins float so the other master can take them.
  wire bus_float = hold_on && I_HOLD_GRANT;
  wire bus_drive = !bus_float;

  // Multiplexed address/data: the address leaves while the latch strobe is high,
  // then the same pins carry write data. Trade-off: no turnaround gap is inserted,
  // the bus controller must leave one between address and read data.
  wire [15:0] ad_value = I_BUS_ALE ? I_BUS_ADDR[15:0] : I_BUS_WDATA;
  wire        ad_drive = (I_BUS_ALE || I_BUS_DATA_DRIVE) && bus_drive;
  wire        d_drive  = I_BUS_DATA_DRIVE && bus_drive;
  wire [15:0] dq_value = cfg.muxed ? ad_value : I_BUS_WDATA;
  wire        dq_drive = cfg.muxed ? ad_drive : d_drive;

  // Port 0: low data byte or low address/data byte.
  wire        p0_sel = ext_bus;
  wire [15:0] p0_d   = pin_byte(p0_sel, dq_value[7:0], {8{dq_drive}},
                                cfg.gpio_out[0], cfg.gpio_dir[0]);

  // Port 1: upper data byte only with a 16-bit non-multiplexed bus, always when muxed.
  wire        p1_sel = cfg.muxed || (non_mux && cfg.bus16);
  wire [15:0] p1_d   = pin_byte(p1_sel, dq_value[15:8], {8{dq_drive}},
                                cfg.gpio_out[1], cfg.gpio_dir[1]);

  // Ports 2 and 3: separate address outputs only when not multiplexed.
  wire [15:0] p2_d = pin_byte(non_mux, I_BUS_ADDR[7:0], {8{bus_drive}},
                              cfg.gpio_out[2], cfg.gpio_dir[2]);
  wire [15:0] p3_d = pin_byte(non_mux, I_BUS_ADDR[15:8], {8{bus_drive}},
                              cfg.gpio_out[3], cfg.gpio_dir[3]);

  // Port 4: upper address byte under software control.
  wire        p4_sel = cfg.ctrl[CTRL_UPPER_ADDR];
  wire [15:0] p4_d   = pin_byte(p4_sel, I_BUS_ADDR[23:16], {8{bus_drive}},
                                cfg.gpio_out[4], cfg.gpio_dir[4]);

  // Port 5: per-bit function selects, values and drives of the control pins.
  wire [7:0] p5_sel;
  wire [7:0] p5_fval;
  wire [7:0] p5_fdrv;
  assign p5_sel[0] = cfg.ctrl[CTRL_CLK_OUT];
  assign p5_sel[1] = cfg.ctrl[CTRL_READY];
  assign p5_sel[2] = hold_on;
  assign p5_sel[3] = hold_on;
  assign p5_sel[4] = ext_bus && cfg.bus16 && cfg.ctrl[CTRL_WRH];
  assign p5_sel[5] = cfg.ctrl[CTRL_WRL];
  assign p5_sel[6] = ext_bus;
  assign p5_sel[7] = ext_bus;
  assign p5_fval   = {I_BUS_ALE, I_BUS_RD_N, I_BUS_WRL_N, I_BUS_WRH_N,
                      1'b0, I_HOLD_GRANT, 1'b0, I_MACHINE_CLK};
  // Ready and hold request are inputs; the acknowledge keeps driving during hold.
  assign p5_fdrv   = {bus_drive, bus_drive, bus_drive, bus_drive, 1'b0, 1'b1, 1'b0, 1'b1};

  // Port 5 per-bit choice between function and GPIO.
  logic [15:0] p5_d;
  always_comb begin
    p5_d = 16'h0000;
    for (int b = 0; b < 8; b++) begin
      p5_d[b]     = p5_sel[b] ? p5_fval[b] : cfg.gpio_out[5][b];
      p5_d[b + 8] = p5_sel[b] ? p5_fdrv[b] : cfg.gpio_dir[5][b];
    end
  end

  // Open-drain port: value always low, enable only where the latch holds a zero.
  wire [7:0] od_oe_n_d = cfg.gpio_out[6];

  // Inputs from the pins towards the bus controller.
  wire ready_d = cfg.ctrl[CTRL_READY] ? I_PORT5_GPIO_IN[1] : 1'b1;
  wire hreq_d  = hold_on && I_PORT5_GPIO_IN[3];

  // Every pin output is registered; in standby all pins release.
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST || I_HW_STANDBY_IN) begin
      O_PORT0_GPIO_OE_N     <= BYTE_ONES;
      O_PORT1_GPIO_OE_N     <= BYTE_ONES;
      O_PORT2_GPIO_OE_N     <= BYTE_ONES;
      O_PORT3_GPIO_OE_N     <= BYTE_ONES;
      O_PORT4_GPIO_OE_N     <= BYTE_ONES;
      O_PORT5_GPIO_OE_N     <= BYTE_ONES;
      O_OPENDRAIN_PORT_OE_N <= BYTE_ONES;
    end else begin
      O_PORT0_GPIO_OE_N     <= ~p0_d[15:8];
      O_PORT1_GPIO_OE_N     <= ~p1_d[15:8];
      O_PORT2_GPIO_OE_N     <= ~p2_d[15:8];
      O_PORT3_GPIO_OE_N     <= ~p3_d[15:8];
      O_PORT4_GPIO_OE_N     <= ~p4_d[15:8];
      O_PORT5_GPIO_OE_N     <= ~p5_d[15:8];
      O_OPENDRAIN_PORT_OE_N <= od_oe_n_d;
    end
  end

  // Output values and bus-side inputs.
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_PORT0_GPIO_OUT     <= BYTE_ZERO;
      O_PORT1_GPIO_OUT     <= BYTE_ZERO;
      O_PORT2_GPIO_OUT     <= BYTE_ZERO;
      O_PORT3_GPIO_OUT     <= BYTE_ZERO;
      O_PORT4_GPIO_OUT     <= BYTE_ZERO;
      O_PORT5_GPIO_OUT     <= BYTE_ZERO;
      O_OPENDRAIN_PORT_OUT <= BYTE_ZERO;
      O_BUS_RDATA          <= 16'h0000;
      O_EXT_READY          <= 1'b1;
      O_HOLD_REQUEST       <= 1'b0;
    end else begin
      O_PORT0_GPIO_OUT     <= p0_d[7:0];
      O_PORT1_GPIO_OUT     <= p1_d[7:0];
      O_PORT2_GPIO_OUT     <= p2_d[7:0];
      O_PORT3_GPIO_OUT     <= p3_d[7:0];
      O_PORT4_GPIO_OUT     <= p4_d[7:0];
      O_PORT5_GPIO_OUT     <= p5_d[7:0];
      O_OPENDRAIN_PORT_OUT <= BYTE_ZERO;
      O_BUS_RDATA          <= {I_PORT1_GPIO_IN, I_PORT0_GPIO_IN};
      O_EXT_READY          <= ready_d;
      O_HOLD_REQUEST       <= hreq_d;
    end
  end
endmodule : epf_top
`default_nettype wire

/* File: sim/epf_ext_mem.sv */
// Behavioural memory on the far side of the address/data pins.
// Assumes ALE, read strobe and address come from resolved pin levels.
`timescale 1ns/10ps
`default_nettype none
module epf_ext_mem (
  input  wire logic        i_clk,
  input  wire logic        i_ale,
  input  wire logic        i_rd_n,
  input  wire logic [15:0] i_addr,
  output logic      [15:0] o_data
);
  logic [15:0] adr_q;
  initial o_data = 16'h5A5A;
  // Latch the address while ALE is high, as an external address latch would.
  // A released bus toggles every cycle, so stale data never passes for a read.
  always_ff @(posedge i_clk) begin
    if (i_ale)
      adr_q <= i_addr;
    o_data <= !i_rd_n ? adr_q ^ 16'hA5C3 : ~o_data;
  end
endmodule : epf_ext_mem
`default_nettype wire

/* File: sim/epf_top_checker.sv */
// Concurrent checks of the pin multiplexer, seeing only the top ports.
// Assumes the mode pins move only while reset is high.
`timescale 1ns/10ps
`default_nettype none
module epf_top_checker (
  input wire logic        I_CLOCK,
  input wire logic        I_SRST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic [2:0]  I_MODE_SELECT_PINS,
  input wire logic        I_HW_STANDBY_IN,
  input wire logic        I_HOLD_GRANT,
  input wire logic [23:0] I_BUS_ADDR,
  input wire logic [15:0] I_BUS_WDATA,
  input wire logic        I_BUS_DATA_DRIVE,
  input wire logic        I_BUS_ALE,
  input wire logic        I_BUS_RD_N,
  input wire logic        I_MACHINE_CLK,
  input wire logic [7:0]  I_PORT5_GPIO_IN,
  input wire logic        O_EXT_READY,
  input wire logic        O_HOLD_REQUEST,
  input wire logic [7:0]  O_PORT0_GPIO_OUT,
  input wire logic [7:0]  O_PORT1_GPIO_OUT,
  input wire logic [7:0]  O_PORT1_GPIO_OE_N,
  input wire logic [7:0]  O_PORT2_GPIO_OUT,
  input wire logic [7:0]  O_PORT2_GPIO_OE_N,
  input wire logic [7:0]  O_PORT5_GPIO_OUT,
  input wire logic [7:0]  O_PORT5_GPIO_OE_N,
  input wire logic [7:0]  O_OPENDRAIN_PORT_OUT
);
  import epf_pkg::*;
  logic [1:0] run_q;
  logic [5:0] ctl_q;
  logic       ok, ext, mux;
  // Shadow of the control word; the mode is trusted only once its latch has settled.
  always_ff @(posedge I_CLOCK) begin
    run_q <= I_SRST ? 2'h0 : (run_q == 2'h3 ? run_q : run_q + 2'h1);
    if (I_SRST)
      ctl_q <= CTRL_RESET;
    else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == OFF_CTRL)
      ctl_q <= I_PWDATA[5:0];
  end
  // Standby and hold grant release pins, so function checks skip those cycles.
  assign ok  = run_q == 2'h3 && !I_HW_STANDBY_IN && !I_HOLD_GRANT;
  assign ext = I_MODE_SELECT_PINS >= MODE_NMUX8 && I_MODE_SELECT_PINS <= MODE_MUX16;
  assign mux = I_MODE_SELECT_PINS == MODE_MUX8 || I_MODE_SELECT_PINS == MODE_MUX16;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  AST_OD_LOW_ONLY: assert property (O_OPENDRAIN_PORT_OUT == 8'h00)
    else $error("open-drain port driven high");
  AST_RESET_RELEASE: assert property ($fell(I_SRST) |-> O_PORT5_GPIO_OE_N == 8'hFF)
    else $error("pins not released by reset");
  AST_MUX_AD: assert property ($past(ok) && mux && $past(I_BUS_ALE) |->
    {O_PORT1_GPIO_OUT, O_PORT0_GPIO_OUT} == $past(I_BUS_ADDR[15:0]) && O_PORT1_GPIO_OE_N == 8'h00)
    else $error("address not on multiplexed bus");
  AST_NMUX_ADDR: assert property (ok && ext && !mux |=>
    O_PORT2_GPIO_OUT == $past(I_BUS_ADDR[7:0]) && O_PORT2_GPIO_OE_N == 8'h00)
    else $error("low address byte missing");
  AST_NMUX16_DATA: assert property (ok && I_BUS_DATA_DRIVE ##0 I_MODE_SELECT_PINS == MODE_NMUX16 |=>
    O_PORT1_GPIO_OUT == $past(I_BUS_WDATA[15:8]) && O_PORT1_GPIO_OE_N == 8'h00)
    else $error("upper data byte missing");
  AST_CLK_OUT: assert property ($past(ok && ctl_q[CTRL_CLK_OUT]) |->
    O_PORT5_GPIO_OUT[0] == $past(I_MACHINE_CLK) && !O_PORT5_GPIO_OE_N[0])
    else $error("clock output wrong");
  AST_READY: assert property (ok && ctl_q[CTRL_READY] |=>
    O_EXT_READY == $past(I_PORT5_GPIO_IN[1]) && O_PORT5_GPIO_OE_N[1])
    else $error("ready input wrong");
  AST_HOLD_REQ: assert property (run_q == 2'h3 |=>
    O_HOLD_REQUEST == ($past(I_PORT5_GPIO_IN[3]) && $past(ctl_q[CTRL_HOLD])))
    else $error("hold request wrong");
  AST_STROBES: assert property ($past(ok) && ext |->
    O_PORT5_GPIO_OUT[7:6] == $past({I_BUS_ALE, I_BUS_RD_N}) && O_PORT5_GPIO_OE_N[7:6] == 2'h0)
    else $error("read or latch strobe wrong");
  COV_MUX_ALE: cover property (ok && mux && I_BUS_ALE);
  COV_ALL_FUNCS: cover property (ok && ctl_q == 6'h3F);
  COV_READ16: cover property (ok && I_MODE_SELECT_PINS == MODE_NMUX16 && !I_BUS_RD_N);
endmodule : epf_top_checker
bind epf_top epf_top_checker chk_u (.*);
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench: every mode, register checks, random bus traffic and a memory read.
// Assumes the checker binds itself and the memory model sits on ports 0 and 1.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import epf_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr;
  logic        ale = 1'b0, rd_n = 1'b1, wrl_n = 1'b1, wrh_n = 1'b1, mclk = 1'b0, drv = 1'b0;
  logic        hgnt = 1'b0, stby = 1'b0, ext_rdy, hreq;
  logic [2:0]  mode = 3'h0;
  logic [5:0]  ctl = 6'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00005C04;
  logic [23:0] baddr = 24'h0;
  logic [15:0] wdata = 16'h0, rdata, mem_d;
  logic [7:0]  p_out [7], p_oe [7], pin [7], lat [7], dir [7], noise = 8'h5A;
  int          error_cnt = 0, n_tests = 0, cyc = 0;
  // Pin level: the device where it drives, else the memory, the pull-up, or a moving pattern.
  for (genvar g = 0; g < 7; g++) begin : g_pin
    assign pin[g] = (~p_oe[g] & p_out[g])
                  | (p_oe[g] & (g < 2 ? mem_d[8*(g%2) +: 8] : (g == 6 ? 8'hFF : noise)));
  end
  epf_top dut_u (.I_CLOCK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_MODE_SELECT_PINS(mode), .I_HW_STANDBY_IN(stby), .I_BUS_ADDR(baddr), .I_BUS_WDATA(wdata),
    .I_BUS_DATA_DRIVE(drv), .I_BUS_ALE(ale), .I_BUS_RD_N(rd_n), .I_BUS_WRL_N(wrl_n),
    .I_BUS_WRH_N(wrh_n), .I_MACHINE_CLK(mclk), .I_HOLD_GRANT(hgnt), .O_BUS_RDATA(rdata),
    .O_EXT_READY(ext_rdy), .O_HOLD_REQUEST(hreq),
    .I_PORT0_GPIO_IN(pin[0]), .O_PORT0_GPIO_OUT(p_out[0]), .O_PORT0_GPIO_OE_N(p_oe[0]),
    .I_PORT1_GPIO_IN(pin[1]), .O_PORT1_GPIO_OUT(p_out[1]), .O_PORT1_GPIO_OE_N(p_oe[1]),
    .I_PORT2_GPIO_IN(pin[2]), .O_PORT2_GPIO_OUT(p_out[2]), .O_PORT2_GPIO_OE_N(p_oe[2]),
    .I_PORT3_GPIO_IN(pin[3]), .O_PORT3_GPIO_OUT(p_out[3]), .O_PORT3_GPIO_OE_N(p_oe[3]),
    .I_PORT4_GPIO_IN(pin[4]), .O_PORT4_GPIO_OUT(p_out[4]), .O_PORT4_GPIO_OE_N(p_oe[4]),
    .I_PORT5_GPIO_IN(pin[5]), .O_PORT5_GPIO_OUT(p_out[5]), .O_PORT5_GPIO_OE_N(p_oe[5]),
    .I_OPENDRAIN_PORT_IN(pin[6]), .O_OPENDRAIN_PORT_OUT(p_out[6]),
    .O_OPENDRAIN_PORT_OE_N(p_oe[6]));
  epf_ext_mem mem_u (.i_clk(clk), .i_ale(pin[5][7]), .i_rd_n(pin[5][6]),
    .i_addr(mode inside {MODE_MUX8, MODE_MUX16} ? {pin[1], pin[0]} : {pin[3], pin[2]}),
    .o_data(mem_d));
  initial forever #5 clk = ~clk;
  // Moving pattern for undriven pins, and the hang guard; a normal run takes some 1600 cycles.
  always @(posedge clk) begin
    noise <= {noise[6:0], ~noise[7]};
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is sampled high or the wait count of 20 runs out.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    e = pslverr;
    {psel, pen} <= 2'b00;
  endtask : apb
  // Random bus controller traffic; quiet cycles drive data with no hold or standby.
  task automatic traffic(input logic quiet);
    logic [31:0] r;
    logic [31:0] s;
    r = rnd();
    s = rnd();
    if (quiet)
      r[7:5] = 3'h4;
    @(posedge clk);
    {baddr, drv, hgnt, stby, ale, rd_n, wrl_n, wrh_n, mclk} <= r;
    wdata <= s[15:0];
  endtask : traffic
  // Expected {mask, oe_n, out} of one port under the current mode, control and bus inputs.
  function automatic logic [31:0] expect_port(input int n);
    logic        ext, mux;
    logic [15:0] f, k;
    ext = mode inside {[MODE_NMUX8:MODE_MUX16]};
    mux = mode inside {MODE_MUX8, MODE_MUX16};
    f = {~dir[n], lat[n]};
    k = 16'hFFFF;
    case (n)
      0: f = !ext ? f : {8'h00, mux && ale ? baddr[7:0] : wdata[7:0]};
      1: f = mux ? {8'h00, ale ? baddr[15:8] : wdata[15:8]}
             : (mode == MODE_NMUX16 ? {8'h00, wdata[15:8]} : f);
      2: f = ext && !mux ? {8'h00, baddr[7:0]} : f;
      3: f = ext && !mux ? {8'h00, baddr[15:8]} : f;
      4: f = ctl[CTRL_UPPER_ADDR] ? {8'h00, baddr[23:16]} : f;
      5: begin
        if (ctl[CTRL_CLK_OUT]) {f[8], f[0]} = {1'b0, mclk};
        if (ctl[CTRL_READY]) {f[9], k[1]} = 2'b10;
        if (ctl[CTRL_HOLD]) {f[10], k[2], f[11], k[3]} = 4'b0010;
        if (ctl[CTRL_WRH] && mode inside {MODE_NMUX16, MODE_MUX16}) {f[12], f[4]} = {1'b0, wrh_n};
        if (ctl[CTRL_WRL]) {f[13], f[5]} = {1'b0, wrl_n};
        if (ext) {f[15:14], f[7:6]} = {2'b00, ale, rd_n};
      end
      default: f = {lat[6], 8'h00};
    endcase
    return {k, f};
  endfunction : expect_port
  task automatic check_pins();
    logic [31:0] x;
    repeat (2) @(posedge clk);
    for (int n = 0; n < 7; n++) begin
      x = expect_port(n);
      chk($sformatf("port%0d", n), {16'h0, x[15:0] & x[31:16]}, {16'h0, {p_oe[n], p_out[n]} & x[31:16]});
    end
  endtask : check_pins
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Each mode is entered through reset, since the mode pins are tied statically.
  initial begin
    logic [31:0] r;
    logic        e;
    for (int md = 0; md < 6; md++) begin
      @(posedge clk);
      {srst, mode} <= {1'b1, md[2:0]};
      repeat (8) @(posedge clk);
      chk("reset oe_n", 32'hFF, {24'h0, p_oe[0] & p_oe[5] & p_oe[6]});
      srst <= 1'b0;
      apb(1'b0, OFF_STATUS, 32'h0, r, e);
      chk("status", {29'h0, md == 2 || md == 4, md == 3 || md == 4, md == 0 || md > 4}, {29'h0, r[5:3]});
      apb(1'b0, md[0] ? 12'h011 : 12'h030, 32'h0, r, e);
      chk("slverr", 32'h1, {31'h0, e});
      chk("unmapped", 32'h0, r);
      for (int c = 0; c < 3; c++) begin
        r = rnd();
        ctl = c == 0 ? 6'h00 : (c == 1 ? 6'h3F : r[5:0]);
        apb(1'b1, OFF_CTRL, {26'h0, ctl}, r, e);
        apb(1'b0, OFF_CTRL, 32'h0, r, e);
        chk("ctrl", {26'h0, ctl}, r);
        for (int n = 0; n < 7; n++) begin
          r = rnd();
          {dir[n], lat[n]} = r[15:0];
          apb(1'b1, OFF_PORT0 + 12'(4 * n), {16'h0, r[15:0]}, r, e);
          apb(1'b0, OFF_PORT0 + 12'(4 * n), 32'h0, r, e);
          chk("port reg", {16'h0, dir[n], lat[n]}, {16'h0, r[15:0]});
        end
        repeat (4) begin
          traffic(1'b0);
          traffic(1'b1);
          check_pins();
        end
      end
      if (md inside {[1:4]}) begin
        r = rnd();
        @(posedge clk);
        {baddr, ale, rd_n, drv, hgnt, stby} <= {r[23:0], 5'b11100};
        repeat (3) @(posedge clk);
        {ale, drv, rd_n} <= 3'b000;
        repeat (4) @(posedge clk);
        chk("read data", {16'h0, (r[15:0] ^ 16'hA5C3) & (md[0] ? 16'h00FF : 16'hFFFF)}, {16'h0, rdata & (md[0] ? 16'h00FF : 16'hFFFF)});
      end
      $display("mode %0d done", md);
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
